// [logic/sipd_pkg.sv]
package sipd_pkg;
    // Register byte offsets on the Avalon slave
    localparam logic [4:0]  OFS_CMD      = 5'h00;
    localparam logic [4:0]  OFS_RET      = 5'h04;
    localparam logic [4:0]  OFS_TBASE    = 5'h08;
    localparam logic [4:0]  OFS_SBASE    = 5'h0c;
    localparam logic [4:0]  OFS_STAT     = 5'h10;
    localparam logic [4:0]  OFS_LVEC     = 5'h14;
    localparam logic [4:0]  OFS_NFP      = 5'h18;
    localparam logic [31:0] TBASE_RST    = 32'h0000_0000;
    localparam logic [31:0] SBASE_RST    = 32'h0000_0000;
    // Command word layout
    localparam int          CMD_LIT_BIT  = 31;
    localparam logic [7:0]  MSG_REQ_INT  = 8'h00;
    localparam logic [7:0]  VEC_MIN_OK   = 8'h08;
    // Status word layout
    localparam int          ST_BUSY_BIT  = 0;
    localparam int          ST_INTD_BIT  = 1;
    localparam int          ST_SUPV_BIT  = 2;
    localparam int          ST_PRI_LSB   = 8;
    localparam int          ST_ERR_BIT   = 16;
    // Table layout: priority word, then vector words
    localparam logic [31:0] TBL_PRI_OFS  = 32'h0000_0000;
    localparam logic [31:0] TBL_VEC_OFS  = 32'h0000_0004;
    // Record offsets below the new frame pointer
    localparam logic [31:0] REC_PC_OFS   = 32'h0000_0010;
    localparam logic [31:0] REC_AC_OFS   = 32'h0000_000c;
    localparam logic [31:0] REC_VEC_OFS  = 32'h0000_0008;
    localparam logic [31:0] REC_FP_OFS   = 32'h0000_0004;
    localparam logic [31:0] FRAME_BYTES  = 32'h0000_0040;
    // Process controls layout
    localparam int          PC_PRI_LSB   = 16;
    localparam int          PC_STATE_BIT = 13;
    localparam int          PC_MODE_BIT  = 1;
    localparam logic [31:0] PC_RST       = 32'h0000_0000;
    localparam logic [4:0]  PRI_TOP      = 5'h1f;

    typedef struct packed {
        logic        req;
        logic        we;
        logic        lock;
        logic [31:0] addr;
        logic [31:0] wdata;
    } sipd_mreq_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } sipd_mrsp_s;

    typedef struct packed {
        logic        valid;
        logic [7:0]  vector;
        logic [31:0] new_frame_pointer;
    } sipd_svc_s;

    typedef enum {
        ST_IDLE, ST_PRD, ST_PVRD, ST_PVWR, ST_PPWR, ST_SCAN,
        ST_DRD, ST_DVRD, ST_DVWR, ST_DPWR,
        ST_REC_PC, ST_REC_AC, ST_REC_VEC, ST_REC_FP,
        ST_RET_PC, ST_RET_AC, ST_RET_FP
    } sipd_state_e;
endpackage

// [logic/sipd_core.sv]
`timescale 1ns/1ps
// Operation
// RULE_01 - Lock spans priority read to write; both bits set.
// RULE_02 - Direct table writes start nothing and leave software priority.
// RULE_03 - Vector 0 to 7 only rescans the table.
// RULE_04 - Outside posters modify atomically, vector bit first.
// RULE_05 - Posting ends with a table scan.
// RULE_06 - Ties: largest vector first; found ones count as new.
// RULE_07 - Type 00h requests; vector is operand low byte.
// RULE_08 - Literal posts vectors 8 to 31, type implied zero.
// RULE_09 - Posting sets both table bits atomically.
// RULE_10 - Posting loads software priority with top table priority.
// RULE_11 - Software priority above both rivals requests service.
// RULE_12 - Service picks top vector and clears its bits.
// RULE_13 - Then next table priority loads software priority.
// RULE_14 - Software priority is hidden; changed only by posting or service.
// RULE_15 - Stack grows upward from a base set at start.
// RULE_16 - Record beside new frame: process controls at -16, arith controls at -12.
// RULE_17 - Handler call allocates a new stack frame.
// RULE_18 - Handling switches to supervisor mode.
// RULE_19 - Handlers start on word boundaries.
// RULE_20 - Background task interrupted: move to interrupt stack.
// RULE_21 - Nested interrupt stays on the interrupt stack.
// RULE_22 - Handler end restores the interrupted state.
// RULE_23 - Service only above current priority, strictly.
// RULE_24 - Priority 31 interrupts priority 31 execution.
// RULE_25 - Table: 32-bit priority field, then 256-bit vector field.
// RULE_26 - A tie with either rival does not signal; code signals a tie at 31 with the current priority.
module sipd_core (
    input  wire logic                 mclk_i,
    input  wire logic                 resetn_i,
    input  wire logic                 ce_i,
    input  wire logic [4:0]           avs_address_i,
    input  wire logic                 avs_read_i,
    input  wire logic                 avs_write_i,
    input  wire logic [31:0]          avs_writedata_i,
    input  wire logic [3:0]           avs_byteenable_i,
    output logic      [31:0]          avs_readdata_o,
    output logic                      avs_waitrequest_o,
    output sipd_pkg::sipd_mreq_s      mem_o,
    input  wire sipd_pkg::sipd_mrsp_s mem_i,
    input  wire logic                 hw_valid_i,
    input  wire logic [4:0]           hw_prio_i,
    input  wire logic [31:0]          arith_controls_i,
    output logic [31:0]               arith_controls_o,
    output logic                      arith_restore_o,
    output sipd_pkg::sipd_svc_s       svc_o,
    output logic                      sw_request_o,
    output logic                      supervisor_o
);
    import sipd_pkg::*;

    sipd_state_e state_q;
    sipd_mreq_s  mreq_q;
    sipd_svc_s   svc_q;
    logic [31:0] tbase_q, sbase_q, sp_q, nfp_q, rb_q, x_q, t_q, pc_q, ac_q;
    logic [31:0] rdata_q, rmux;
    logic [7:0]  vec_q;
    logic [4:0]  p_q, swp_q;
    logic        swv_q, have_q, err_q, rd_pend_q, acr_q;

    function automatic logic [4:0] msb32(input logic [31:0] v);
        msb32 = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (v[i]) msb32 = 5'(i);
        end
    endfunction

    function automatic sipd_mreq_s mk(input logic we, input logic lk, input logic [31:0] a,
                                      input logic [31:0] d);
        mk = '{req: 1'b1, we: we, lock: lk, addr: a, wdata: d};
    endfunction

    // Decoded command fields
    logic        busy, intd, cmd_wr, ret_wr, stat_wr, sw_fire;
    logic [4:0]  cur_pri, rd_msb;
    logic [7:0]  c_vec, c_msg;
    logic [31:0] c_vaddr, p_vaddr, nfp_new;
    assign busy    = (state_q != ST_IDLE);
    assign intd    = pc_q[PC_STATE_BIT];
    assign cur_pri = pc_q[PC_PRI_LSB +: 5];
    assign cmd_wr  = ce_i && avs_write_i && (avs_address_i == OFS_CMD) && !busy;
    assign ret_wr  = ce_i && avs_write_i && (avs_address_i == OFS_RET) && !busy;
    assign stat_wr = ce_i && avs_write_i && (avs_address_i == OFS_STAT);
    assign c_vec   = avs_writedata_i[CMD_LIT_BIT] ? {3'h0, avs_writedata_i[4:0]}
                                                  : avs_writedata_i[7:0];           // see RULE_07 see RULE_08
    assign c_msg   = avs_writedata_i[CMD_LIT_BIT] ? MSG_REQ_INT : avs_writedata_i[15:8]; // see RULE_08
    // Vector byte v/8 lives at table offset 4 + v/8
    assign c_vaddr = tbase_q + TBL_VEC_OFS + {27'h0, vec_q[7:5], 2'b00};           // see RULE_25
    assign p_vaddr = tbase_q + TBL_VEC_OFS + {27'h0, p_q[4:2], 2'b00};
    assign nfp_new = rb_q + REC_PC_OFS;
    assign rd_msb  = msb32(mem_i.rdata);

    // Strict compare against both rivals; 31 may preempt 31
    assign sw_fire = swv_q && ((swp_q > cur_pri) || (swp_q == PRI_TOP && cur_pri == PRI_TOP)) // see RULE_23 see RULE_24
                     && (!hw_valid_i || (swp_q > hw_prio_i));                            // see RULE_11 see RULE_26
    assign sw_request_o = sw_fire;

    // Largest vector in the top priority's byte
    logic [7:0]  dv_byte;
    logic [2:0]  dv_bit;
    logic [4:0]  dv_msb;
    logic [31:0] dv_word, dv_x;
    always_comb begin
        dv_byte = mem_i.rdata[{p_q[1:0], 3'b000} +: 8];
        dv_msb  = msb32({24'h0, dv_byte});
        dv_bit  = dv_msb[2:0];                                                       // see RULE_06
        dv_word = mem_i.rdata & ~(32'h1 << {p_q[1:0], dv_bit});                      // see RULE_12
        dv_x    = x_q;
        if ((dv_byte & ~(8'h1 << dv_bit)) == 8'h00) begin
            dv_x = x_q & ~(32'h1 << p_q);                                            // see RULE_12
        end
    end

    // Sequencer and memory master
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= ST_IDLE;
            mreq_q  <= '0;
            svc_q   <= '0;
            pc_q    <= PC_RST;
            ac_q    <= '0;
            acr_q   <= 1'b0;
            sp_q    <= '0;
            nfp_q   <= '0;
            rb_q    <= '0;
            x_q     <= '0;
            t_q     <= '0;
            vec_q   <= '0;
            p_q     <= '0;
            swp_q   <= '0;
            swv_q   <= 1'b0;
            have_q  <= 1'b0;
        end else if (ce_i) begin
            svc_q.valid <= 1'b0;
            acr_q       <= 1'b0;
            if (mem_i.ack) mreq_q.req <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (cmd_wr && c_msg == MSG_REQ_INT) begin
                        vec_q <= c_vec;
                        if (c_vec < VEC_MIN_OK) begin
                            mreq_q  <= mk(1'b0, 1'b0, tbase_q + TBL_PRI_OFS, '0);    // see RULE_03
                            state_q <= ST_SCAN;
                        end else begin
                            mreq_q  <= mk(1'b0, 1'b1, tbase_q + TBL_PRI_OFS, '0);    // see RULE_01
                            state_q <= ST_PRD;
                        end
                    end else if (ret_wr && intd) begin
                        mreq_q  <= mk(1'b0, 1'b0, nfp_q - REC_PC_OFS, '0);           // see RULE_22
                        state_q <= ST_RET_PC;
                    end else if (!cmd_wr && !ret_wr && sw_fire) begin                // see RULE_02
                        mreq_q  <= mk(1'b0, 1'b1, tbase_q + TBL_PRI_OFS, '0);        // see RULE_12
                        state_q <= ST_DRD;
                    end
                end
                ST_PRD: if (mem_i.ack) begin
                    x_q     <= mem_i.rdata;
                    mreq_q  <= mk(1'b0, 1'b1, c_vaddr, '0);
                    state_q <= ST_PVRD;
                end
                ST_PVRD: if (mem_i.ack) begin
                    mreq_q  <= mk(1'b1, 1'b1, mreq_q.addr, mem_i.rdata | (32'h1 << vec_q[4:0])); // see RULE_09
                    state_q <= ST_PVWR;
                end
                ST_PVWR: if (mem_i.ack) begin
                    mreq_q  <= mk(1'b1, 1'b1, tbase_q + TBL_PRI_OFS, x_q | (32'h1 << vec_q[7:3])); // see RULE_01
                    state_q <= ST_PPWR;
                end
                ST_PPWR: if (mem_i.ack) begin
                    mreq_q  <= mk(1'b0, 1'b0, tbase_q + TBL_PRI_OFS, '0);            // see RULE_05
                    state_q <= ST_SCAN;
                end
                ST_SCAN: if (mem_i.ack) begin
                    swv_q   <= |mem_i.rdata;                                         // see RULE_10 see RULE_14
                    swp_q   <= rd_msb;                                               // see RULE_10
                    state_q <= ST_IDLE;
                end
                ST_DRD: if (mem_i.ack) begin
                    x_q    <= mem_i.rdata;
                    p_q    <= rd_msb;
                    have_q <= |mem_i.rdata;
                    if (mem_i.rdata == 32'h0) begin
                        // Empty table: write back to end the lock
                        mreq_q  <= mk(1'b1, 1'b1, tbase_q + TBL_PRI_OFS, mem_i.rdata);
                        state_q <= ST_DPWR;
                    end else begin
                        mreq_q  <= mk(1'b0, 1'b1, tbase_q + TBL_VEC_OFS + {27'h0, rd_msb[4:2], 2'b00}, '0);
                        state_q <= ST_DVRD;
                    end
                end
                ST_DVRD: if (mem_i.ack) begin
                    vec_q   <= {p_q, dv_bit};                                        // see RULE_06
                    x_q     <= dv_x;
                    have_q  <= (dv_byte != 8'h00);
                    mreq_q  <= mk(1'b1, 1'b1, p_vaddr, dv_word);                     // see RULE_12
                    state_q <= ST_DVWR;
                end
                ST_DVWR: if (mem_i.ack) begin
                    mreq_q  <= mk(1'b1, 1'b1, tbase_q + TBL_PRI_OFS, x_q);
                    state_q <= ST_DPWR;
                end
                ST_DPWR: if (mem_i.ack) begin
                    swv_q <= |x_q;                                                   // see RULE_13 see RULE_14
                    swp_q <= msb32(x_q);                                             // see RULE_13
                    if (have_q) begin
                        // Background moves to stack base; handler stays
                        rb_q    <= intd ? sp_q : sbase_q;                            // see RULE_20 see RULE_21
                        mreq_q  <= mk(1'b1, 1'b0, intd ? sp_q : sbase_q, pc_q);      // see RULE_16
                        state_q <= ST_REC_PC;
                    end else begin
                        mreq_q.lock <= 1'b0;                                         // see RULE_01
                        state_q     <= ST_IDLE;
                    end
                end
                ST_REC_PC: if (mem_i.ack) begin
                    mreq_q  <= mk(1'b1, 1'b0, nfp_new - REC_AC_OFS, arith_controls_i); // see RULE_16
                    state_q <= ST_REC_AC;
                end
                ST_REC_AC: if (mem_i.ack) begin
                    mreq_q  <= mk(1'b1, 1'b0, nfp_new - REC_VEC_OFS, {24'h0, vec_q});
                    state_q <= ST_REC_VEC;
                end
                ST_REC_VEC: if (mem_i.ack) begin
                    mreq_q  <= mk(1'b1, 1'b0, nfp_new - REC_FP_OFS, nfp_q);
                    state_q <= ST_REC_FP;
                end
                ST_REC_FP: if (mem_i.ack) begin
                    nfp_q   <= nfp_new;
                    sp_q    <= nfp_new + FRAME_BYTES;                                // see RULE_15 see RULE_17
                    pc_q[PC_PRI_LSB +: 5] <= p_q;
                    pc_q[PC_STATE_BIT]    <= 1'b1;
                    pc_q[PC_MODE_BIT]     <= 1'b1;                                   // see RULE_18
                    svc_q   <= '{valid: 1'b1, vector: vec_q, new_frame_pointer: nfp_new};
                    state_q <= ST_IDLE;
                end
                ST_RET_PC: if (mem_i.ack) begin
                    t_q     <= mem_i.rdata;
                    mreq_q  <= mk(1'b0, 1'b0, nfp_q - REC_AC_OFS, '0);
                    state_q <= ST_RET_AC;
                end
                ST_RET_AC: if (mem_i.ack) begin
                    ac_q    <= mem_i.rdata;
                    mreq_q  <= mk(1'b0, 1'b0, nfp_q - REC_FP_OFS, '0);
                    state_q <= ST_RET_FP;
                end
                ST_RET_FP: if (mem_i.ack) begin
                    pc_q    <= t_q;                                                  // see RULE_22
                    acr_q   <= 1'b1;
                    sp_q    <= nfp_q - REC_PC_OFS;                                   // see RULE_21
                    nfp_q   <= mem_i.rdata;
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Base pointers, set by software at start
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tbase_q <= TBASE_RST;
            sbase_q <= SBASE_RST;
        end else if (ce_i && avs_write_i) begin
            for (int b = 0; b < 4; b++) begin
                if (avs_byteenable_i[b] && avs_address_i == OFS_TBASE) tbase_q[b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
                if (avs_byteenable_i[b] && avs_address_i == OFS_SBASE) sbase_q[b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
            end
        end
    end

    // Sticky error: a new fault beats a clear
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            err_q <= 1'b0;
        end else if (ce_i) begin
            if ((cmd_wr && c_msg != MSG_REQ_INT) || (ret_wr && !intd)) err_q <= 1'b1;
            else if (stat_wr && avs_writedata_i[ST_ERR_BIT]) err_q <= 1'b0;
        end
    end

    // Read mux; software priority has no window
    always_comb begin
        rmux = 32'h0;
        if (avs_address_i == OFS_TBASE) begin
            rmux = tbase_q;
        end else if (avs_address_i == OFS_SBASE) begin
            rmux = sbase_q;
        end else if (avs_address_i == OFS_STAT) begin                                // see RULE_14
            rmux[ST_BUSY_BIT]         = busy;
            rmux[ST_INTD_BIT]         = intd;
            rmux[ST_SUPV_BIT]         = pc_q[PC_MODE_BIT];
            rmux[ST_PRI_LSB +: 5]     = cur_pri;
            rmux[ST_ERR_BIT]          = err_q;
        end else if (avs_address_i == OFS_LVEC) begin
            rmux = {24'h0, svc_q.vector};
        end else if (avs_address_i == OFS_NFP) begin
            rmux = nfp_q;
        end
    end

    // Reads take two edges; data from a flop
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_pend_q <= 1'b0;
            rdata_q   <= '0;
        end else if (ce_i) begin
            rd_pend_q <= avs_read_i && !rd_pend_q;
            if (avs_read_i && !rd_pend_q) rdata_q <= rmux;
        end
    end

    // Commands stall while busy, so none is dropped
    assign avs_waitrequest_o = !ce_i || (avs_read_i && !rd_pend_q)
                               || (avs_write_i && busy && (avs_address_i == OFS_CMD || avs_address_i == OFS_RET));
    assign avs_readdata_o    = rdata_q;
    assign mem_o             = mreq_q;
    assign svc_o             = svc_q;
    assign arith_controls_o  = ac_q;
    assign arith_restore_o   = acr_q;
    assign supervisor_o      = pc_q[PC_MODE_BIT];
endmodule // sipd_core

// [sim/sipd_mem.sv]
`timescale 1ns/1ps
module sipd_mem import sipd_pkg::*; (
    input  wire logic       mclk_i,
    input  wire logic       resetn_i,
    input  wire logic [1:0] lat_i,
    input  wire sipd_mreq_s req_i,
    output sipd_mrsp_s      rsp_o
);
    logic [31:0] ram [0:255];
    logic [1:0]  wait_q;
    // Table starts empty
    initial begin
        for (int i = 0; i < 256; i++) begin
            ram[i] = 32'h0;
        end
    end
    // Acked after lat_i idle cycles
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wait_q <= 2'h0;
            rsp_o  <= '0;
        end else begin
            rsp_o.ack   <= 1'b0;
            rsp_o.rdata <= ~rsp_o.rdata; // Garbage outside an ack
            if (req_i.req && !rsp_o.ack) begin
                if (wait_q != lat_i) begin
                    wait_q <= wait_q + 2'h1;
                end else begin
                    wait_q      <= 2'h0;
                    rsp_o.ack   <= 1'b1;
                    rsp_o.rdata <= ram[req_i.addr[9:2]];
                    if (req_i.we) begin
                        ram[req_i.addr[9:2]] <= req_i.wdata;
                    end
                end
            end
        end
    end
endmodule // sipd_mem

// [sim/sipd_core_asserts.sv]
`timescale 1ns/1ps
module sipd_core_asserts import sipd_pkg::*; (
    input wire logic        mclk_i,
    input wire logic        resetn_i,
    input wire logic [4:0]  avs_address_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic        avs_waitrequest_o,
    input wire sipd_mreq_s  mem_o,
    input wire logic        hw_valid_i,
    input wire logic [4:0]  hw_prio_i,
    input wire sipd_svc_s   svc_o,
    input wire logic        sw_request_o,
    input wire logic        supervisor_o,
    input wire logic        arith_restore_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    logic        cmd_ok;
    logic [31:0] wd;
    // Accepted command
    assign cmd_ok = avs_write_i && !avs_waitrequest_o && avs_address_i == OFS_CMD;
    assign wd     = avs_writedata_i;

    property p_lock_open;
        $rose(mem_o.lock) |-> mem_o.req && !mem_o.we;
    endproperty
    a_lock_open: assert property (p_lock_open) else $error("lock open");
    property p_lock_close;
        $fell(mem_o.lock) |-> $past(mem_o.we);
    endproperty
    a_lock_close: assert property (p_lock_close) else $error("lock close");
    property p_rescan;
        cmd_ok && !wd[31] && wd[15:8] == MSG_REQ_INT && wd[7:0] < VEC_MIN_OK |=> mem_o.req && !mem_o.lock && !mem_o.we;
    endproperty
    a_rescan: assert property (p_rescan) else $error("rescan");
    property p_post;
        cmd_ok && !wd[31] && wd[15:8] == MSG_REQ_INT && wd[7:0] >= VEC_MIN_OK |=> mem_o.req && mem_o.lock;
    endproperty
    a_post: assert property (p_post) else $error("post");
    property p_literal;
        cmd_ok && wd[31] && wd[4:0] >= 5'h08 |=> mem_o.req && mem_o.lock && !mem_o.we;
    endproperty
    a_literal: assert property (p_literal) else $error("literal");
    property p_bad_type;
        cmd_ok && !wd[31] && wd[15:8] != MSG_REQ_INT && !sw_request_o |=> !mem_o.req;
    endproperty
    a_bad_type: assert property (p_bad_type) else $error("bad type");
    property p_hw_top;
        hw_valid_i && hw_prio_i == PRI_TOP |-> !sw_request_o;
    endproperty
    a_hw_top: assert property (p_hw_top) else $error("hw tie");
    property p_super;
        svc_o.valid |=> supervisor_o;
    endproperty
    a_super: assert property (p_super) else $error("supervisor");
    property p_record;
        svc_o.valid |-> $past(mem_o.we) && $past(mem_o.addr) == svc_o.new_frame_pointer - REC_FP_OFS;
    endproperty
    a_record: assert property (p_record) else $error("record");
    property p_no_spont;
        $rose(mem_o.req) |-> $past(avs_write_i) || $past(sw_request_o);
    endproperty
    a_no_spont: assert property (p_no_spont) else $error("no cause");
    c_svc: cover property (svc_o.valid);
    c_restore: cover property (arith_restore_o);
    c_lock: cover property ($rose(mem_o.lock));
endmodule // sipd_core_asserts

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
    import sipd_pkg::*;
    logic        mclk_i, resetn_i, avs_read_i, avs_write_i, hw_valid_i;
    logic        avs_waitrequest_o, arith_restore_o, sw_request_o, supervisor_o;
    logic [4:0]  avs_address_i, hw_prio_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, arith_controls_i, arith_controls_o, sv_nfp, ac_seen, q;
    logic [7:0]  sv_vec;
    logic [1:0]  lat;
    sipd_mreq_s  mem_o;
    sipd_mrsp_s  mem_i;
    sipd_svc_s   svc_o;
    int          n_svc = 0;
    int          n_fail = 0;
    int          total_checks = 0;

    sipd_core u_sipd_core (.mclk_i, .resetn_i, .ce_i(1'b1), .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o, .avs_waitrequest_o, .mem_o, .mem_i,
        .hw_valid_i, .hw_prio_i, .arith_controls_i, .arith_controls_o, .arith_restore_o, .svc_o,
        .sw_request_o, .supervisor_o);
    sipd_mem u_sipd_mem (.mclk_i, .resetn_i, .lat_i(lat), .req_i(mem_o), .rsp_o(mem_i));

    // 250 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    // Capture one-cycle pulses
    always @(posedge mclk_i) begin
        if (svc_o.valid === 1'b1) begin
            sv_vec <= svc_o.vector;
            sv_nfp <= svc_o.new_frame_pointer;
            n_svc  <= n_svc + 1;
        end
        if (arith_restore_o === 1'b1) begin
            ac_seen <= arith_controls_o;
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask
    // Held until waitrequest low at a rising edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge mclk_i);
        avs_read_i      <= !w;
        avs_write_i     <= w;
        avs_address_i   <= a;
        avs_writedata_i <= d;
        do begin
            @(posedge mclk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 400);
        q = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
        if (n >= 400) begin
            chk(32'h1, 32'h0, "bus timeout");
            wrap_up();
        end
    endtask
    task automatic rchk(input logic [4:0] a, input logic [31:0] e, input string what);
        bus(1'b0, a, 32'h0);
        chk(q, e, what);
    endtask
    // Poll until quiet
    task automatic idle();
        int n = 0;
        do begin
            bus(1'b0, OFS_STAT, 32'h0);
            n++;
        end while ((q[ST_BUSY_BIT] !== 1'b0 || sw_request_o !== 1'b0) && n < 200);
        if (n >= 200) begin
            chk(32'h1, 32'h0, "idle timeout");
            wrap_up();
        end
    endtask
    task automatic rec(input int i, input logic [31:0] pc, ac, v, fp);
        chk(u_sipd_mem.ram[i], pc, "rec pc");
        chk(u_sipd_mem.ram[i+1], ac, "rec ac");
        chk(u_sipd_mem.ram[i+2], v, "rec vec");
        chk(u_sipd_mem.ram[i+3], fp, "rec fp");
    endtask
    initial begin
        resetn_i         = 1'b0;
        avs_read_i       = 1'b0;
        avs_write_i      = 1'b0;
        avs_address_i    = 5'h0;
        avs_writedata_i  = 32'h0;
        hw_valid_i       = 1'b0;
        hw_prio_i        = 5'h0;
        arith_controls_i = 32'h0000_3a5c;
        lat              = 2'h0;
        repeat (5) @(posedge mclk_i);
        resetn_i <= 1'b1;
        // Resets, unmapped, bases
        rchk(OFS_TBASE, TBASE_RST, "tbase rst");
        rchk(OFS_STAT, 32'h0, "stat rst");
        bus(1'b1, 5'h1c, 32'hffff_ffff);
        rchk(5'h1c, 32'h0, "unmapped");
        bus(1'b1, OFS_TBASE, 32'h0000_0100);
        bus(1'b1, OFS_SBASE, 32'h0000_0200);
        rchk(OFS_SBASE, 32'h0000_0200, "sbase");
        $display("test regs done");
        // Direct post, vector 10h
        u_sipd_mem.ram[65][16] = 1'b1;
        u_sipd_mem.ram[64][2]  = 1'b1;
        repeat (20) @(posedge mclk_i);
        chk(32'(sw_request_o), 32'h0, "quiet");
        bus(1'b1, OFS_CMD, 32'h0000_0005);
        idle();
        chk(32'(sv_vec), 32'h10, "vector");
        chk(sv_nfp, 32'h0000_0210, "nfp");
        rec(128, 32'h0, 32'h0000_3a5c, 32'h10, 32'h0);
        chk(u_sipd_mem.ram[65] | u_sipd_mem.ram[64], 32'h0, "cleared");
        rchk(OFS_STAT, 32'h0000_0206, "stat handler");
        rchk(OFS_NFP, 32'h0000_0210, "nfp reg");
        $display("test rescan done");
        // 50h and 53h at priority 10
        u_sipd_mem.ram[67][16] = 1'b1;
        u_sipd_mem.ram[64][10] = 1'b1;
        hw_valid_i <= 1'b1;
        hw_prio_i  <= 5'd10;
        lat        <= 2'h3;
        bus(1'b1, OFS_CMD, 32'h0000_0053);
        idle();
        chk(32'(n_svc), 32'h1, "held by hw");
        chk(u_sipd_mem.ram[67], 32'h0009_0000, "posted vec");
        chk(u_sipd_mem.ram[64], 32'h0000_0400, "posted pri");
        hw_prio_i <= 5'd9;
        idle();
        chk(32'(sv_vec), 32'h53, "largest");
        rec(148, 32'h0002_2002, 32'h0000_3a5c, 32'h53, 32'h210);
        chk(u_sipd_mem.ram[67], 32'h0001_0000, "other kept");
        hw_valid_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        chk(32'(sw_request_o), 32'h0, "equal held");
        $display("test nest done");
        // Return, then 50h
        arith_controls_i <= 32'h0000_05a1;
        bus(1'b1, OFS_RET, 32'h0);
        idle();
        chk(ac_seen, 32'h0000_3a5c, "ac");
        chk(32'(sv_vec), 32'h50, "next");
        rec(148, 32'h0002_2002, 32'h0000_05a1, 32'h50, 32'h210);
        chk(u_sipd_mem.ram[64], 32'h0, "empty");
        $display("test return done");
        // Bad type, literal post
        hw_valid_i <= 1'b1;
        hw_prio_i  <= 5'h1f;
        bus(1'b1, OFS_CMD, 32'h0000_0153);
        rchk(OFS_STAT, 32'h0001_0a06, "bad type");
        bus(1'b1, OFS_STAT, 32'h0001_0000);
        bus(1'b1, OFS_CMD, 32'h8000_001f);
        idle();
        chk(u_sipd_mem.ram[65] | u_sipd_mem.ram[64], 32'h8000_0008, "literal");
        rchk(OFS_STAT, 32'h0000_0a06, "err clr");
        $display("test literal done");
        wrap_up();
    end
endmodule // tb

bind sipd_core sipd_core_asserts u_chk (.mclk_i, .resetn_i, .avs_address_i, .avs_write_i, .avs_writedata_i,
    .avs_waitrequest_o, .mem_o, .hw_valid_i, .hw_prio_i, .svc_o, .sw_request_o, .supervisor_o, .arith_restore_o);
